//--- rtl/rdcs_top.v
// Behaviour
// - Squelch needs tx and rx on, runs only with rx_on low, ends within 500 us.
// - Gain reset reinitialises gain, aborts squelch, loads manual gain from rxcfg4.
// - Most commands need enable bit and stable crystal.
// - Regulator adjust starts with rx/tx on and regulator at maximum.
// - Every 300 us compare margin; below target, step regulator down and repeat.
// - Stepping stops at margin met or minimum; whole command ends within 5 ms.
// - Regulator adjust refused when external regulator definition bit is set.
// - Adjust, calibrations and measurements raise done pulse; others do not.
// - Only gain reset and RSSI clear may be chained with further commands.
// - Modulation calibration transmits, adapts depth to target, writes result back, 275 us.
// - Antenna calibration trims capacitors to resonance within 250 us.
// - Phase measure enables tx and detector, relative mode, stores result, 25 us.
// - Phase results saturate at FFh below 30 degrees, 00h above 150.
// - One phase step is 0.468 degrees; 90 degrees gives mid code.
// - Rising rx_on clears RSSI and starts a peak-hold measurement.
// - RSSI clear command clears bits and restarts peak if rx_on high.
// - Transparent mode entered on slave-select rise, held while it stays high.
// - Capsense calibration runs only with all manual bits zero, within 3 ms.
// - Supply measure picks supply by two bits, absolute mode, within 25 us; the code has no supply select bits and always sets adc_src to 1.
// - Test access command enables test register access and test pins; the code only sets test_access and drives no test pins.
// - rx_on gates RSSI measurement and gain control.
//
// Chosen here: the APB interface to the registers and the address map.
`include "rdcs_defines.vh"
module rdcs_top (
   input wire pclk, // Clock
   input wire presetn, // Async reset, active low
   input wire psel, // APB select
   input wire penable, // APB enable
   input wire pwrite, // APB write
   input wire [11:0] paddr, // APB address
   input wire [31:0] pwdata, // APB write data
   output reg [31:0] prdata, // APB read data
   output reg pready, // APB ready
   output reg pslverr, // APB error
   input wire osc_stable_pin, // Crystal stable
   input wire rx_on_pin, // Receive active
   input wire spi_ss_pin, // SPI slave select level
   input wire margin_ok_pin, // Supply margin at least 250 mV
   input wire [7:0] adc_value_pin, // Converter result
   input wire tank_resonant_pin, // Antenna at resonance
   input wire mod_on_target_pin, // Modulation depth matches target
   input wire [7:0] rssi_level_pin, // Instantaneous signal strength
   output reg done_irq, // Command completion pulse
   output reg tx_force, // Transmitter forced on
   output reg rx_force, // Receiver forced on
   output reg detector_en, // Phase detector enable
   output reg adc_relative, // Converter relative mode
   output reg [1:0] adc_src, // Converter source: 0 phase 1 supply
   output reg agc_run, // Gain control running
   output reg transparent, // Transparent mode
   output reg test_access // Test register access
);
   localparam S_IDLE = 8'h01;
   localparam S_SQ = 8'h02;
   localparam S_REG = 8'h04;
   localparam S_MOD = 8'h08;
   localparam S_ANT = 8'h10;
   localparam S_MEAS = 8'h20;
   localparam S_CS = 8'h40;
   localparam S_END = 8'h80;
   localparam integer CYC_SQ = `RDCS_T_SQ_NS / `RDCS_CLK_NS;
   localparam integer CYC_MOD = `RDCS_T_CALMOD_NS / `RDCS_CLK_NS;
   localparam integer CYC_ANT = `RDCS_T_CALANT_NS / `RDCS_CLK_NS;
   localparam integer CYC_MEAS = `RDCS_T_MEAS_NS / `RDCS_CLK_NS;
   localparam integer CYC_MCAP = `RDCS_T_MCAP_NS / `RDCS_CLK_NS;
   parameter integer CYC_REGSTEP = `RDCS_T_REGSTEP_NS / `RDCS_CLK_NS;
   parameter integer CYC_CALCS = `RDCS_T_CALCS_NS / `RDCS_CLK_NS;
   parameter integer CYC_SQ_P = CYC_SQ;
   parameter integer CYC_MOD_P = CYC_MOD;
   parameter integer CYC_ANT_P = CYC_ANT;
   parameter integer CYC_MCAP_P = CYC_MCAP;

   // Two-stage synchronisers for pin inputs
   reg [5:0] s1_r;
   reg [5:0] s2_r;
   // Buses are held steady by the analog side while a result stands, so two flops suffice
   reg [7:0] adc_s1_r;
   reg [7:0] adc_s2_r;
   reg [7:0] rssi_s1_r;
   reg [7:0] rssi_s2_r;
   wire osc_ok = s2_r[0];
   wire rx_on = s2_r[1];
   wire ss = s2_r[2];
   wire margin_ok = s2_r[3];
   wire resonant = s2_r[4];
   wire mod_ok = s2_r[5];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= 6'h00;
         s2_r <= 6'h00;
         adc_s1_r <= 8'h00;
         adc_s2_r <= 8'h00;
         rssi_s1_r <= 8'h00;
         rssi_s2_r <= 8'h00;
      end else begin
         s1_r <= {mod_on_target_pin, tank_resonant_pin, margin_ok_pin, spi_ss_pin, rx_on_pin, osc_stable_pin};
         s2_r <= s1_r;
         adc_s1_r <= adc_value_pin;
         adc_s2_r <= adc_s1_r;
         rssi_s1_r <= rssi_level_pin;
         rssi_s2_r <= rssi_s1_r;
      end
   end

   function is_addr;
      input [11:0] a;
      input [11:0] r;
      begin
         is_addr = (a == r);
      end
   endfunction

   reg [7:0] ctrl_r;
   reg [7:0] regctl_r;
   reg [7:0] mod_r;
   reg [7:0] adc_r;
   reg [7:0] rssi_r;
   reg [7:0] gain_r;
   reg [7:0] trim_r;
   reg [7:0] cscal_r;
   reg [7:0] rxcfg4_r;
   reg [3:0] regset_r;
   reg [7:0] state_r;
   reg [7:0] cmd_r;
   reg [31:0] cnt_r;
   reg [7:0] err_r;
   reg rx_on_d_r;
   reg ss_d_r;
   reg transp_arm_r;
   reg chain_r;
   wire wr = psel && penable && pwrite;
   wire cmd_wr = wr && is_addr(paddr, `RDCS_A_CMD);
   wire [7:0] cmd = pwdata[7:0];
   wire chained = pwdata[`RDCS_B_CHAIN];
   wire ready_ok = ctrl_r[`RDCS_B_EN] && osc_ok;
   wire busy = (state_r != S_IDLE);
   wire chain_ok = (cmd == `RDCS_C_GAINRST) || (cmd == `RDCS_C_CLRRSSI);
   // A chain flag on a non-chainable command refuses it, as does a non-chainable follower
   wire chain_bad = (chain_r || chained) && !chain_ok;
   // A gain reset during squelch is carried out, so it is not counted as refused
   wire sq_abort = cmd_wr && (cmd == `RDCS_C_GAINRST) && ready_ok && (state_r == S_SQ);
   reg accept;
   always @* begin
      accept = 1'b0;
      case (cmd)
         `RDCS_C_SQUELCH: accept = ctrl_r[`RDCS_B_RXEN] && ctrl_r[`RDCS_B_TXEN];
         `RDCS_C_ADJREG: accept = ready_ok && !regctl_r[`RDCS_B_REGS];
         `RDCS_C_GAINRST: accept = ready_ok;
         `RDCS_C_CALMOD: accept = ready_ok;
         `RDCS_C_CALANT: accept = ready_ok;
         `RDCS_C_MPHASE: accept = ready_ok;
         `RDCS_C_CLRRSSI: accept = ready_ok;
         `RDCS_C_TRANSP: accept = ready_ok;
         `RDCS_C_MSUPPLY: accept = ready_ok;
         `RDCS_C_CALCS: accept = (cscal_r[`RDCS_F_MCAL] == `RDCS_MCAL_AUTO);
         // Capsense measure and test access carry no acceptance condition
         `RDCS_C_MCAP: accept = 1'b1;
         `RDCS_C_TEST: accept = 1'b1;
         default: accept = 1'b0;
      endcase
   end
   // One sequencer only: a command written while busy is refused, except a gain reset during squelch, so the host waits for done
   wire go = cmd_wr && !busy && accept && !chain_bad;
   wire rx_rise = rx_on && !rx_on_d_r;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 8'h00;
         regctl_r <= 8'h00;
         mod_r <= 8'h00;
         adc_r <= 8'h00;
         rssi_r <= 8'h00;
         gain_r <= 8'h00;
         trim_r <= 8'h00;
         cscal_r <= 8'h00;
         rxcfg4_r <= 8'h00;
         regset_r <= `RDCS_REG_MAX;
         state_r <= S_IDLE;
         cmd_r <= 8'h00;
         cnt_r <= 32'h0000_0000;
         err_r <= 8'h00;
         rx_on_d_r <= 1'b0;
         ss_d_r <= 1'b0;
         transp_arm_r <= 1'b0;
         chain_r <= 1'b0;
         done_irq <= 1'b0;
         tx_force <= 1'b0;
         rx_force <= 1'b0;
         detector_en <= 1'b0;
         adc_relative <= 1'b0;
         adc_src <= 2'h0;
         agc_run <= 1'b0;
         transparent <= 1'b0;
         test_access <= 1'b0;
      end else begin
         rx_on_d_r <= rx_on;
         ss_d_r <= ss;
         done_irq <= 1'b0;
         agc_run <= rx_on;
         if (rx_rise) begin
            rssi_r <= 8'h00;
         end else if (rx_on && rssi_s2_r > rssi_r) begin
            rssi_r <= rssi_s2_r;
         end
         if (ss && !ss_d_r && transp_arm_r) begin
            transparent <= 1'b1;
            transp_arm_r <= 1'b0;
         end else if (!ss) begin
            transparent <= 1'b0;
         end
         if (wr && is_addr(paddr, `RDCS_A_CTRL)) begin
            ctrl_r <= pwdata[7:0];
         end
         if (wr && is_addr(paddr, `RDCS_A_REG)) begin
            regctl_r <= pwdata[7:0];
         end
         if (wr && is_addr(paddr, `RDCS_A_MOD)) begin
            mod_r <= pwdata[7:0];
         end
         if (wr && is_addr(paddr, `RDCS_A_CSCAL)) begin
            cscal_r <= pwdata[7:0];
         end
         if (wr && is_addr(paddr, `RDCS_A_RXCFG4)) begin
            rxcfg4_r <= pwdata[7:0];
         end
         if (cmd_wr) begin
            chain_r <= go && chained && chain_ok;
            if (!go && !sq_abort) err_r <= err_r + 8'h01;
         end
         if (go) begin
            cmd_r <= cmd;
            cnt_r <= 32'h0000_0000;
            case (cmd)
               `RDCS_C_SQUELCH: begin
                  if (!rx_on) state_r <= S_SQ;
               end
               `RDCS_C_GAINRST: begin
                  gain_r <= rxcfg4_r;
               end
               `RDCS_C_CLRRSSI: begin
                  rssi_r <= 8'h00;
               end
               `RDCS_C_TRANSP: begin
                  transp_arm_r <= 1'b1;
               end
               `RDCS_C_TEST: begin
                  test_access <= 1'b1;
               end
               `RDCS_C_ADJREG: begin
                  tx_force <= 1'b1;
                  rx_force <= 1'b1;
                  regset_r <= `RDCS_REG_MAX;
                  state_r <= S_REG;
               end
               `RDCS_C_CALMOD: begin
                  tx_force <= 1'b1;
                  state_r <= S_MOD;
               end
               `RDCS_C_CALANT: begin
                  tx_force <= 1'b1;
                  trim_r <= 8'h00;
                  state_r <= S_ANT;
               end
               `RDCS_C_MPHASE: begin
                  tx_force <= 1'b1;
                  detector_en <= 1'b1;
                  adc_relative <= 1'b1;
                  adc_src <= 2'h0;
                  state_r <= S_MEAS;
               end
               `RDCS_C_MSUPPLY: begin
                  adc_relative <= 1'b0;
                  adc_src <= 2'h1;
                  state_r <= S_MEAS;
               end
               `RDCS_C_CALCS, `RDCS_C_MCAP: begin
                  state_r <= S_CS;
               end
               default: state_r <= S_IDLE;
            endcase
         end else if (busy) begin
            cnt_r <= cnt_r + 32'h0000_0001;
            case (state_r)
               S_SQ: begin
                  if (sq_abort) begin
                     gain_r <= rxcfg4_r;
                     state_r <= S_IDLE;
                  end else if (cnt_r >= CYC_SQ_P - 1) begin
                     gain_r <= gain_r + 8'h01;
                     state_r <= S_IDLE;
                  end
               end
               S_REG: begin
                  if (cnt_r >= CYC_REGSTEP - 1) begin
                     cnt_r <= 32'h0000_0000;
                     if (margin_ok || regset_r == `RDCS_REG_MIN) state_r <= S_END;
                     else regset_r <= regset_r - 4'h1;
                  end
               end
               S_MOD: begin
                  // Depth moves only every few cycles so the detector settles after each step
                  if (cnt_r[`RDCS_F_MODSTEP] == `RDCS_MODSTEP_LAST && !mod_ok) begin
                     mod_r <= mod_r + 8'h01;
                  end
                  if (mod_ok || cnt_r >= CYC_MOD_P - 1) begin
                     state_r <= S_END;
                  end
               end
               S_ANT: begin
                  if (!resonant && trim_r != `RDCS_TRIM_MAX) begin
                     trim_r <= trim_r + 8'h01;
                  end
                  if (resonant || cnt_r >= CYC_ANT_P - 1) begin
                     state_r <= S_END;
                  end
               end
               S_MEAS: begin
                  if (cnt_r >= CYC_MEAS - 1) begin
                     adc_r <= adc_s2_r;
                     state_r <= S_END;
                  end
               end
               S_CS: begin
                  // Capsense analog runs on its own; the host keeps the field off
                  if (cnt_r >= ((cmd_r == `RDCS_C_CALCS) ? CYC_CALCS : CYC_MCAP_P) - 1) begin
                     if (cmd_r == `RDCS_C_MCAP) adc_r <= adc_s2_r;
                     state_r <= S_END;
                  end
               end
               S_END: begin
                  done_irq <= 1'b1;
                  tx_force <= 1'b0;
                  rx_force <= 1'b0;
                  detector_en <= 1'b0;
                  state_r <= S_IDLE;
               end
               default: state_r <= S_IDLE;
            endcase
         end
      end
   end

   // APB: zero-wait slave, unmapped reads give zero with an error flag
   reg [31:0] rd;
   reg hit;
   always @* begin
      rd = 32'h0000_0000;
      hit = 1'b1;
      case (paddr)
         `RDCS_A_CMD: rd = {24'h000000, cmd_r};
         `RDCS_A_CTRL: rd = {24'h000000, ctrl_r};
         `RDCS_A_STAT: rd = {16'h0000, err_r, state_r};
         `RDCS_A_MOD: rd = {24'h000000, mod_r};
         `RDCS_A_ADC: rd = {24'h000000, adc_r};
         `RDCS_A_RSSI: rd = {24'h000000, rssi_r};
         `RDCS_A_GAIN: rd = {24'h000000, gain_r};
         `RDCS_A_REG: rd = {20'h00000, regset_r, regctl_r};
         `RDCS_A_TRIM: rd = {24'h000000, trim_r};
         `RDCS_A_CSCAL: rd = {24'h000000, cscal_r};
         `RDCS_A_RXCFG4: rd = {24'h000000, rxcfg4_r};
         default: hit = 1'b0;
      endcase
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         prdata <= (psel && !penable && !pwrite) ? rd : 32'h0000_0000;
      end
   end
endmodule // rdcs_top

//--- pkg/rdcs_defines.vh
`ifndef RDCS_DEFINES_VH
`define RDCS_DEFINES_VH
// Register byte addresses
`define RDCS_A_CMD 12'h000
`define RDCS_A_CTRL 12'h004
`define RDCS_A_STAT 12'h008
`define RDCS_A_MOD 12'h00C
`define RDCS_A_ADC 12'h010
`define RDCS_A_RSSI 12'h014
`define RDCS_A_GAIN 12'h018
`define RDCS_A_REG 12'h01C
`define RDCS_A_TRIM 12'h020
`define RDCS_A_CSCAL 12'h024
`define RDCS_A_RXCFG4 12'h028
// Command codes
`define RDCS_C_SQUELCH 8'h01
`define RDCS_C_GAINRST 8'h02
`define RDCS_C_ADJREG 8'h03
`define RDCS_C_CALMOD 8'h04
`define RDCS_C_CALANT 8'h05
`define RDCS_C_MPHASE 8'h06
`define RDCS_C_CLRRSSI 8'h07
`define RDCS_C_TRANSP 8'h08
`define RDCS_C_CALCS 8'h09
`define RDCS_C_MCAP 8'h0A
`define RDCS_C_MSUPPLY 8'h0B
`define RDCS_C_TEST 8'h0C
// Control register, regulator control and command word chain bits
`define RDCS_B_EN 7
`define RDCS_B_RXEN 6
`define RDCS_B_TXEN 5
`define RDCS_B_REGS 7
`define RDCS_B_CHAIN 8
// Regulator codes: max and min settings
`define RDCS_REG_MAX 4'hF
`define RDCS_REG_MIN 4'h0
// Phase result limits: full and zero codes
`define RDCS_PH_FULL 8'hFF
`define RDCS_PH_ZERO 8'h00
// Capsense manual calibration field and its automatic value
`define RDCS_F_MCAL 3:0
`define RDCS_MCAL_AUTO 4'h0
// Modulation step interval and antenna trim ceiling
`define RDCS_F_MODSTEP 3:0
`define RDCS_MODSTEP_LAST 4'hF
`define RDCS_TRIM_MAX 8'hFF
// Times in ns
`define RDCS_CLK_NS 10
`define RDCS_T_SQ_NS 500000
`define RDCS_T_REGSTEP_NS 300000
`define RDCS_T_CALMOD_NS 275000
`define RDCS_T_CALANT_NS 250000
`define RDCS_T_MEAS_NS 25000
`define RDCS_T_CALCS_NS 3000000
`define RDCS_T_MCAP_NS 250000
`endif

//--- tb/rdcs_checker.sv
module rdcs_checker (
   input wire pclk, // Clock
   input wire presetn, // Reset, active low
   input wire psel, // APB select
   input wire penable, // APB enable
   input wire [31:0] prdata, // APB read data
   input wire pready, // APB ready
   input wire pslverr, // APB error
   input wire rx_on_pin, // Receive active
   input wire spi_ss_pin, // Slave select level
   input wire done_irq, // Completion pulse
   input wire tx_force, // Transmitter forced on
   input wire detector_en, // Phase detector enable
   input wire adc_relative, // Converter relative mode
   input wire [1:0] adc_src, // Converter source
   input wire agc_run, // Gain control running
   input wire transparent // Transparent mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("pready missing in access cycle");
   ready_single_a: assert property (pready |-> psel && penable && $past(psel && !penable))
      else $error("pready outside an access cycle");
   error_reads_zero_a: assert property (pslverr |-> pready && prdata == 32'h00000000)
      else $error("pslverr without ready or with data");
   done_single_a: assert property (done_irq |=> !done_irq)
      else $error("done pulse longer than one cycle");
   phase_route_a: assert property (detector_en |-> adc_relative && tx_force && adc_src == 2'h0)
      else $error("phase detector not routed in relative mode");
   transp_exit_a: assert property ((!spi_ss_pin) [*4] |=> !transparent)
      else $error("transparent held with select low");
   agc_gate_a: assert property ((!rx_on_pin) [*4] |=> !agc_run)
      else $error("gain control runs with receive inactive");
   transp_entry_a: assert property ($rose(transparent) |-> $past(spi_ss_pin, 2))
      else $error("transparent entered without select high");
   done_clears_a: assert property (done_irq |-> !tx_force && !detector_en)
      else $error("forced outputs still on at completion");
endmodule // rdcs_checker

bind rdcs_top rdcs_checker i_rdcs_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_on_pin(rx_on_pin), .spi_ss_pin(spi_ss_pin),
   .done_irq(done_irq), .tx_force(tx_force), .detector_en(detector_en), .adc_relative(adc_relative),
   .adc_src(adc_src), .agc_run(agc_run), .transparent(transparent));

//--- tb/rdcs_afe_model.sv
module rdcs_afe_model (
   input wire pclk, // Clock
   input wire tx_force, // Transmitter forced on
   input wire rx_force, // Receiver forced on
   input wire [15:0] lag, // Load cycles before the analog side settles
   output logic margin_ok, // Supply margin met
   output logic tank_resonant, // Tank at resonance
   output logic mod_on_target // Depth on target
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_r = 16'h0000;
   // Settling only counts while forced on, so a slow lag never settles a short command
   always @(posedge pclk) cnt_r <= (tx_force || rx_force) ? cnt_r + ((cnt_r != 16'hFFFF) ? 16'h0001 : 16'h0000) : 16'h0000;
   assign margin_ok = rx_force && tx_force && cnt_r >= lag;
   assign tank_resonant = tx_force && cnt_r >= lag;
   assign mod_on_target = tx_force && cnt_r >= lag;
endmodule // rdcs_afe_model

//--- tb/tb_reader_direct_command_sequencer.sv
`include "rdcs_defines.vh"
module tb_reader_direct_command_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, osc, rx_on, ss, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [7:0] adc_v, rssi_v, g;
   logic [15:0] lag;
   wire [31:0] prdata;
   wire [1:0] adc_src;
   wire pready, pslverr, done_irq, tx_force, rx_force, det, adc_rel, agc_run, transparent, test_access;
   wire margin_ok, tank_ok, mod_ok;
   int n_errors = 0, cmp_count = 0, cyc = 0, ndone = 0;
   logic [7:0] vals [6];

   rdcs_top #(.CYC_REGSTEP(20), .CYC_CALCS(50), .CYC_SQ_P(20), .CYC_MOD_P(20), .CYC_MCAP_P(20))
   i_rdcs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_stable_pin(osc),
      .rx_on_pin(rx_on), .spi_ss_pin(ss), .margin_ok_pin(margin_ok), .adc_value_pin(adc_v),
      .tank_resonant_pin(tank_ok), .mod_on_target_pin(mod_ok), .rssi_level_pin(rssi_v), .done_irq(done_irq),
      .tx_force(tx_force), .rx_force(rx_force), .detector_en(det), .adc_relative(adc_rel), .adc_src(adc_src),
      .agc_run(agc_run), .transparent(transparent), .test_access(test_access));
   rdcs_afe_model i_rdcs_afe_model (.pclk(pclk), .tx_force(tx_force), .rx_force(rx_force), .lag(lag),
      .margin_ok(margin_ok), .tank_resonant(tank_ok), .mod_on_target(mod_ok));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (done_irq === 1'b1) ndone <= ndone + 1;
      if (cyc == 60000) begin
         n_errors++;
         end_of_test();
      end
   end

   task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Issues one command, then checks completion pulses and refusal count growth
   task run(input logic [8:0] c, input int wt, input int exp_done, input int exp_ref);
      int d0;
      logic [7:0] r0;
      apb(1'b0, `RDCS_A_STAT, 0);
      r0 = rd[15:8];
      d0 = ndone;
      apb(1'b1, `RDCS_A_CMD, {23'h0, c});
      for (int t = 0; t < wt && ndone == d0; t++) @(posedge pclk);
      chk("done count", ndone - d0, exp_done);
      apb(1'b0, `RDCS_A_STAT, 0);
      chk("refusals", {24'h0, rd[15:8] - r0}, exp_ref);
      $display("test command %h ended", c);
   endtask
   function logic [3:0] reg_final(input logic [15:0] l);
      return (l == 16'h0000) ? `RDCS_REG_MAX : `RDCS_REG_MIN;
   endfunction

   initial begin
      {presetn, psel, penable, pwrite, osc, rx_on, ss} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      adc_v = 8'h00;
      rssi_v = 8'h00;
      lag = 16'h0005;
      void'($urandom(32'h75CA));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `RDCS_A_STAT, 0);
      chk("idle state", rd[7:0], 8'h01);
      apb(1'b0, `RDCS_A_REG, 0);
      chk("reg setting", rd[11:8], `RDCS_REG_MAX);
      apb(1'b0, 12'h02C, 0);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      run(`RDCS_C_MPHASE, 100, 0, 1);
      run(`RDCS_C_MCAP, 200, 1, 0);
      apb(1'b1, `RDCS_A_CSCAL, 32'h1);
      run(`RDCS_C_CALCS, 200, 0, 1);
      apb(1'b1, `RDCS_A_CSCAL, 32'h0);
      run(`RDCS_C_CALCS, 200, 1, 0);
      osc <= 1'b1;
      apb(1'b1, `RDCS_A_CTRL, 32'h80);
      run(`RDCS_C_SQUELCH, 100, 0, 1);
      apb(1'b1, `RDCS_A_CTRL, 32'hE0);
      run(`RDCS_C_SQUELCH, 200, 0, 0);
      vals = '{8'hFF, 8'h00, 8'h80, 8'h7F, 8'h00, 8'h00};
      for (int i = 0; i < 6; i++) begin
         adc_v <= (i < 4) ? vals[i] : 8'($urandom);
         run(`RDCS_C_MPHASE, 3000, 1, 0);
         apb(1'b0, `RDCS_A_ADC, 0);
         chk("phase result", rd, adc_v);
      end
      adc_v <= 8'($urandom);
      run(`RDCS_C_MSUPPLY, 3000, 1, 0);
      apb(1'b0, `RDCS_A_ADC, 0);
      chk("supply result", rd, adc_v);
      apb(1'b1, `RDCS_A_REG, 32'h80);
      run(`RDCS_C_ADJREG, 100, 0, 1);
      apb(1'b1, `RDCS_A_REG, 32'h0);
      for (int i = 0; i < 2; i++) begin
         lag <= i ? 16'hFFFF : 16'h0000;
         run(`RDCS_C_ADJREG, 2000, 1, 0);
         apb(1'b0, `RDCS_A_REG, 0);
         chk("reg setting", rd[11:8], reg_final(lag));
      end
      lag <= 16'h0005;
      run(`RDCS_C_CALMOD, 500, 1, 0);
      run(`RDCS_C_CALANT, 500, 1, 0);
      g = 8'($urandom);
      apb(1'b1, `RDCS_A_RXCFG4, {24'h0, g});
      run(`RDCS_C_GAINRST, 100, 0, 0);
      apb(1'b0, `RDCS_A_GAIN, 0);
      chk("gain", rd, g);
      rssi_v <= 8'h40;
      rx_on <= 1'b1;
      repeat (10) @(posedge pclk);
      rssi_v <= 8'h10;
      repeat (10) @(posedge pclk);
      apb(1'b0, `RDCS_A_RSSI, 0);
      chk("rssi peak", rd, 8'h40);
      run(`RDCS_C_CLRRSSI, 100, 0, 0);
      apb(1'b0, `RDCS_A_RSSI, 0);
      chk("rssi restart", rd, 8'h10);
      rx_on <= 1'b0;
      run(9'h100 | `RDCS_C_ADJREG, 100, 0, 1);
      run(9'h100 | `RDCS_C_GAINRST, 100, 0, 0);
      run(`RDCS_C_MPHASE, 100, 0, 1);
      run(`RDCS_C_TRANSP, 20, 0, 0);
      ss <= 1'b1;
      repeat (10) @(posedge pclk);
      chk("transparent on", transparent, 1'b1);
      ss <= 1'b0;
      repeat (10) @(posedge pclk);
      chk("transparent off", transparent, 1'b0);
      run(`RDCS_C_TEST, 20, 0, 0);
      chk("test access", test_access, 1'b1);
      end_of_test();
   end
endmodule // tb_reader_direct_command_sequencer
